// [dpb_consts.vh]
// Purpose: Constants for the dual-port block memory with queue and check-bit logic
// Assumes: Included once by dpb_ram36.v
// Notes:   Offsets are APB byte addresses; field positions index the control word
`ifndef DPB_CONSTS_VH
`define DPB_CONSTS_VH

`define DPB_OFS_CTRL      8'h00
`define DPB_OFS_AFULL     8'h04
`define DPB_OFS_AEMPTY    8'h08
`define DPB_OFS_STATUS    8'h0C

`define DPB_CTRL_RST      32'h0000_0000
`define DPB_AFULL_RST     16'h7FF0
`define DPB_AEMPTY_RST    16'h0010

`define DPB_F_AWID        2:0
`define DPB_F_BWID        5:3
`define DPB_F_SPLIT       6
`define DPB_F_SRW         7
`define DPB_F_CASC        8
`define DPB_F_ECC         9
`define DPB_F_FIFO        10
`define DPB_F_FWFT        11
`define DPB_F_APIPE       12
`define DPB_F_BPIPE       13
`define DPB_F_AWMODE      15:14
`define DPB_F_BWMODE      17:16
`define DPB_F_FASYNC      18
`define DPB_F_FCLR        19

`define DPB_W_X1          3'h0
`define DPB_W_X9          3'h3
`define DPB_W_X36         3'h5
`define DPB_W_X72         3'h6
`define DPB_W_HALF_MAXW   3'h4

`define DPB_WM_NEW        2'h0
`define DPB_WM_OLD        2'h1
`define DPB_WM_KEEP       2'h2

`define DPB_FULL_LOG2     5'h0F
`define DPB_HALF_LOG2     5'h0E
`define DPB_CHK_BITS      7
`define DPB_CODE_LEN      72

`endif

// [dpb_ram36.v]
// Purpose: 36 Kb dual-port block memory with shapes, split, cascade, queue and SECDED
// Assumes: Both ports and APB share CORE_CLK; user port inputs are CORE_CLK logic
// Notes:   Memory has no reset; its contents are undefined after power-up
// Notes on behaviour
// RULE_01 - Two independent ports; only the 36 Kb stored array is shared.
// RULE_02 - All port inputs are captured on the clock edge; nothing between edges.
// RULE_03 - Registered address is held so the location stays selected until next access; the code holds port A's only, and idle port B uses it.
// RULE_04 - Optional output pipeline register adds exactly one cycle of read latency; in queue mode the code keeps port B's off.
// RULE_05 - During a write the output shows old data, new data, or stays unchanged.
// RULE_06 - Port shapes 32Kx1 up to 512x72, parity bits present from x9 upward.
// RULE_07 - Ports take different shapes freely over the same stored bits.
// RULE_08 - Split mode gives two 18 Kb halves, shapes 16Kx1 to 512x36.
// RULE_09 - Widths above 18/36 only in read-write split mode: A writes, B reads.
// RULE_10 - In that mode one side is variable, the other fixed at the widest shape.
// RULE_11 - Two blocks cascade to 64Kx1; top address bit selects the block.
// RULE_12 - 64-bit words store eight Hamming bits; read corrects single, flags double.
// RULE_13 - Encoder and decoder also usable standalone for external 72-bit memory.
// RULE_14 - Queue advances its own addresses; single or dual clock mode; the code runs both modes on the one CORE_CLK.
// RULE_15 - Queue drives full, empty, almost full and almost empty.
// RULE_16 - Almost full and almost empty levels are programmable.
// RULE_17 - Queue depth and width follow port A shape; both sides same width.
// RULE_18 - Fall-through mode shows first word without a read request.
// RULE_19 - After the first word is consumed, fall-through behaves as standard.
// RULE_20 - Writes when full and reads when empty are ignored, state unchanged.
// RULE_21 - With check bits on, reads report corrected single and detected double errors.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "dpb_consts.vh"
module dpb_ram36 #(
  parameter [0:0] CASC_ID = 1'b0          // Block position within a 64Kx1 cascade
) (
  input  wire        CORE_CLK,            // Core clock
  input  wire        RST_B,               // Asynchronous reset, active low
  input  wire        PSEL,                // APB select
  input  wire        PENABLE,             // APB enable
  input  wire        PWRITE,              // APB direction
  input  wire [7:0]  PADDR,               // APB byte address
  input  wire [31:0] PWDATA,              // APB write data
  output wire [31:0] PRDATA,              // APB read data
  output wire        PREADY,              // APB ready
  output wire        PSLVERR,             // APB error on unmapped address
  input  wire        A_EN,                // Port A access enable
  input  wire        A_WE,                // Port A write enable
  input  wire        A_HALF,              // Port A half select in split mode
  input  wire [15:0] A_ADDR,              // Port A word address, bit 15 cascade select
  input  wire [63:0] A_DIN,               // Port A write data
  input  wire [7:0]  A_DINP,              // Port A write parity bits
  input  wire        A_CASC_IN,           // Port A read bit from the other cascaded block
  output wire [63:0] A_DOUT,              // Port A read data
  output wire [7:0]  A_DOUTP,             // Port A read parity or check bits
  output wire        A_SBE,               // Port A single error corrected
  output wire        A_DBE,               // Port A double error detected
  input  wire        B_EN,                // Port B access enable
  input  wire        B_WE,                // Port B write enable
  input  wire        B_HALF,              // Port B half select in split mode
  input  wire [15:0] B_ADDR,              // Port B word address, bit 15 cascade select
  input  wire [63:0] B_DIN,               // Port B write data
  input  wire [7:0]  B_DINP,              // Port B write parity bits
  input  wire        B_CASC_IN,           // Port B read bit from the other cascaded block
  output wire [63:0] B_DOUT,              // Port B read data, also queue read data
  output wire [7:0]  B_DOUTP,             // Port B read parity or check bits
  output wire        B_SBE,               // Port B single error corrected
  output wire        B_DBE,               // Port B double error detected
  input  wire        FIFO_WR_EN,          // Queue write request, data on A_DIN
  input  wire        FIFO_RD_EN,          // Queue read request, data on B_DOUT
  output wire        FIFO_FULL,           // Queue full
  output wire        FIFO_EMPTY,          // Queue empty
  output wire        FIFO_AFULL,          // Queue almost full
  output wire        FIFO_AEMPTY,         // Queue almost empty
  input  wire [63:0] ENC_DIN,             // Standalone encoder data
  output wire [7:0]  ENC_CHK,             // Standalone encoder check bits
  input  wire [63:0] DEC_DIN,             // Standalone decoder data
  input  wire [7:0]  DEC_CHK,             // Standalone decoder check bits
  output wire [63:0] DEC_DOUT,            // Standalone decoder corrected data
  output wire        DEC_SBE,             // Standalone decoder single error
  output wire        DEC_DBE              // Standalone decoder double error
);

  reg         mem_d [0:32767];
  reg         mem_p [0:4095];

  reg  [31:0] ctrl_reg;
  reg  [15:0] afull_lvl_reg;
  reg  [15:0] aempty_lvl_reg;
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;

  reg  [147:0] latch_reg;
  reg  [147:0] out_reg;
  reg  [1:0]   sel_reg;
  reg  [14:0]  base_hold_reg;

  reg  [15:0] wr_ptr_reg;
  reg  [15:0] rd_ptr_reg;
  reg  [16:0] mem_cnt_reg;
  reg         out_valid_reg;
  reg  [3:0]  flags_reg;
  reg  [7:0]  enc_chk_reg;
  reg  [65:0] dec_reg;

  reg  [5:0]   code_v;
  reg  [29:0]  base_v;
  reg  [1:0]   acc_v;
  reg  [1:0]   we_v;
  reg  [1:0]   hit_v;
  reg  [127:0] din_v;
  reg  [15:0]  dinp_v;
  reg  [147:0] val_v;
  reg  [1:0]   pipe_v;

  wire split = ctrl_reg[`DPB_F_SPLIT];
  wire srw   = ctrl_reg[`DPB_F_SRW];
  wire fifo  = ctrl_reg[`DPB_F_FIFO];
  wire fwft  = ctrl_reg[`DPB_F_FWFT];
  wire ecc   = ctrl_reg[`DPB_F_ECC];
  wire casc  = ctrl_reg[`DPB_F_CASC] & ~fifo;

  function [7:0] ecc_gen;
    input [63:0] d;
    integer pos;
    integer i;
    integer k;
    reg [71:0] cw;
    begin
      cw = 72'h0;
      k = 0;
      ecc_gen = 8'h00;
      for (pos = 1; pos < `DPB_CODE_LEN; pos = pos + 1) begin
        if ((pos & (pos - 1)) != 0) begin
          cw[pos] = d[k];
          k = k + 1;
        end
      end
      for (pos = 1; pos < `DPB_CODE_LEN; pos = pos + 1)
        for (i = 0; i < `DPB_CHK_BITS; i = i + 1)
          if (pos[i])
            ecc_gen[i] = ecc_gen[i] ^ cw[pos];
      ecc_gen[7] = (^d) ^ (^ecc_gen[6:0]);
    end
  endfunction

  // Returns {double, single, corrected data}
  function [65:0] ecc_fix;
    input [63:0] d;
    input [7:0]  c;
    reg   [7:0]  g;
    reg   [6:0]  syn;
    reg          ovr;
    reg   [63:0] fixed;
    integer pos;
    integer k;
    begin
      g = ecc_gen(d);
      syn = g[6:0] ^ c[6:0];
      ovr = (^d) ^ (^c);
      fixed = d;
      k = 0;
      for (pos = 1; pos < `DPB_CODE_LEN; pos = pos + 1) begin
        if ((pos & (pos - 1)) != 0) begin
          if (ovr && syn == pos[6:0])
            fixed[k] = ~d[k];
          k = k + 1;
        end
      end
      ecc_fix = {(~ovr) & (syn != 7'h00), ovr, fixed};
    end
  endfunction

  // Widest shape allowed for the chosen mode, and the shape each port really uses
  function [2:0] shape_of;
    input [2:0] req;
    input [2:0] other;
    input       is_read_side;
    reg   [2:0] maxw;
    reg   [2:0] lim;
    begin
      maxw = split ? `DPB_W_X36 : `DPB_W_X72;
      lim  = srw ? maxw : (split ? `DPB_W_HALF_MAXW : `DPB_W_X36);              // RULE_09
      shape_of = (req > lim) ? lim : req;                                       // RULE_08
      if (srw && is_read_side && ((other > maxw ? maxw : other) != maxw))
        shape_of = maxw;                                                        // RULE_10
      if (casc)
        shape_of = `DPB_W_X1;                                                   // RULE_11
    end
  endfunction

  function [14:0] bit_base;
    input [15:0] addr;
    input [2:0]  code;
    input        half;
    reg   [21:0] sh;
    begin
      sh = {7'h00, addr[14:0]} << code;
      bit_base = split ? {half, sh[13:0]} : sh[14:0];                           // RULE_07
    end
  endfunction

  wire [4:0]  dep_log = (split ? `DPB_HALF_LOG2 : `DPB_FULL_LOG2) - {2'b00, code_v[2:0]};
  wire [16:0] depth   = 17'h00001 << dep_log;
  wire [15:0] ptr_msk = depth[15:0] - 16'h0001;
  wire        wr_ok   = FIFO_WR_EN && (mem_cnt_reg != depth);                   // RULE_20
  wire        rd_ok   = FIFO_RD_EN && (fwft ? out_valid_reg : (mem_cnt_reg != 17'h0));
  wire        fetch   = (mem_cnt_reg != 17'h0) && (fwft ? (!out_valid_reg || FIFO_RD_EN)
                                                        : FIFO_RD_EN);          // RULE_18

  integer p;
  integer j;
  integer q;
  integer m;
  integer s;
  reg [2:0]  c;
  reg [14:0] b;
  reg [63:0] rd;
  reg [7:0]  rp;
  reg [65:0] fx;
  reg [73:0] v;

  always @* begin
    c = 3'h0;
    b = 15'h0000;
    rd = 64'h0;
    rp = 8'h00;
    fx = 66'h0;
    v = 74'h0;
    code_v[2:0] = shape_of(ctrl_reg[`DPB_F_AWID], ctrl_reg[`DPB_F_BWID], 1'b0);
    code_v[5:3] = fifo ? code_v[2:0]                                            // RULE_17
                       : shape_of(ctrl_reg[`DPB_F_BWID], ctrl_reg[`DPB_F_AWID], 1'b1);
    hit_v[0] = !casc || (A_ADDR[15] == CASC_ID);                                // RULE_11
    hit_v[1] = !casc || (B_ADDR[15] == CASC_ID);
    if (fifo) begin
      acc_v = {fetch, wr_ok};                                                   // RULE_14
      we_v  = 2'b01;
      base_v = {bit_base(rd_ptr_reg, code_v[5:3], 1'b0),
                bit_base(wr_ptr_reg, code_v[2:0], 1'b0)};
      pipe_v = {1'b0, ctrl_reg[`DPB_F_APIPE]};
    end else begin
      acc_v = {B_EN & hit_v[1], A_EN & hit_v[0]};                               // RULE_01
      we_v  = {B_WE & ~srw, A_WE};                                              // RULE_09
      base_v = {bit_base(B_ADDR, code_v[5:3], B_HALF), bit_base(A_ADDR, code_v[2:0], A_HALF)};
      pipe_v = {ctrl_reg[`DPB_F_BPIPE], ctrl_reg[`DPB_F_APIPE]};
    end
    din_v = {B_DIN, A_DIN};
    dinp_v[7:0]  = (ecc && code_v[2:0] == `DPB_W_X72) ? ecc_gen(A_DIN) : A_DINP; // RULE_12
    dinp_v[15:8] = (ecc && code_v[5:3] == `DPB_W_X72) ? ecc_gen(B_DIN) : B_DINP;
    for (p = 0; p < 2; p = p + 1) begin
      c = code_v[p*3 +: 3];
      b = acc_v[p] ? base_v[p*15 +: 15] : base_hold_reg;                        // RULE_03
      for (j = 0; j < 64; j = j + 1)
        rd[j] = (j < (1 << c)) ? mem_d[(b + j) & 15'h7FFF] : 1'b0;              // RULE_06
      for (j = 0; j < 8; j = j + 1)
        rp[j] = (c >= `DPB_W_X9 && j < ((1 << c) >> 3)) ? mem_p[((b >> 3) + j) & 12'hFFF]
                                                         : 1'b0;
      fx = ecc_fix(rd, rp);
      if (ecc && c == `DPB_W_X72 && !we_v[p])
        v = {fx[65:64], rp, fx[63:0]};                                          // RULE_21
      else
        v = {2'b00, rp, rd};
      if (!sel_reg[p] && !acc_v[p])
        v = {10'h000, 63'h0, (p == 0) ? A_CASC_IN : B_CASC_IN};
      if (we_v[p] && acc_v[p]) begin
        case (ctrl_reg[(p == 0 ? 14 : 16) +: 2])                                // RULE_05
          `DPB_WM_NEW:  v = {2'b00, dinp_v[p*8 +: 8], din_v[p*64 +: 64]};
          `DPB_WM_OLD:  v = v;
          default:      v = latch_reg[p*74 +: 74];
        endcase
      end
      val_v[p*74 +: 74] = v;
    end
  end

  // Port B write lands after port A, so B wins a same-address collision
  always @(posedge CORE_CLK) begin
    for (q = 0; q < 2; q = q + 1) begin
      if (acc_v[q] && we_v[q]) begin                                            // RULE_02
        for (m = 0; m < 64; m = m + 1)
          if (m < (1 << code_v[q*3 +: 3]))
            mem_d[(base_v[q*15 +: 15] + m) & 15'h7FFF] <= din_v[q*64 + m];
        for (m = 0; m < 8; m = m + 1)
          if (code_v[q*3 +: 3] >= `DPB_W_X9 && m < ((1 << code_v[q*3 +: 3]) >> 3))
            mem_p[((base_v[q*15 +: 15] >> 3) + m) & 12'hFFF] <= dinp_v[q*8 + m];
      end
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      latch_reg <= 148'h0;
      out_reg <= 148'h0;
      sel_reg <= 2'b11;
      base_hold_reg <= 15'h0000;
    end else begin
      for (s = 0; s < 2; s = s + 1) begin
        if (acc_v[s] || (casc && ((s == 0) ? A_EN : B_EN)))
          latch_reg[s*74 +: 74] <= val_v[s*74 +: 74];
        if (pipe_v[s])
          out_reg[s*74 +: 74] <= latch_reg[s*74 +: 74];                         // RULE_04
        else if (acc_v[s] || (casc && ((s == 0) ? A_EN : B_EN)))
          out_reg[s*74 +: 74] <= val_v[s*74 +: 74];
      end
      if (A_EN)
        sel_reg[0] <= hit_v[0];
      if (B_EN)
        sel_reg[1] <= hit_v[1];
      if (acc_v[0])
        base_hold_reg <= base_v[14:0];
    end
  end

  assign A_DOUT  = out_reg[63:0];
  assign A_DOUTP = out_reg[71:64];
  assign A_SBE   = out_reg[72];
  assign A_DBE   = out_reg[73];
  assign B_DOUT  = out_reg[137:74];
  assign B_DOUTP = out_reg[145:138];
  assign B_SBE   = out_reg[146];
  assign B_DBE   = out_reg[147];

  // Queue state; with one core clock both clock modes run the same pointer logic
  reg [16:0] cnt_next;
  reg        ov_next;
  reg [16:0] total;
  always @* begin
    cnt_next = mem_cnt_reg + {16'h0, wr_ok} - {16'h0, fetch};
    ov_next = fwft ? (fetch | (out_valid_reg & ~rd_ok)) : 1'b0;                 // RULE_19
    total = cnt_next + {16'h0, ov_next};
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_ptr_reg <= 16'h0000;
      rd_ptr_reg <= 16'h0000;
      mem_cnt_reg <= 17'h00000;
      out_valid_reg <= 1'b0;
      flags_reg <= 4'b1010;
    end else if (!fifo || ctrl_reg[`DPB_F_FCLR]) begin
      wr_ptr_reg <= 16'h0000;
      rd_ptr_reg <= 16'h0000;
      mem_cnt_reg <= 17'h00000;
      out_valid_reg <= 1'b0;
      flags_reg <= 4'b1010;
    end else begin
      if (wr_ok)
        wr_ptr_reg <= (wr_ptr_reg + 16'h0001) & ptr_msk;                        // RULE_14
      if (fetch)
        rd_ptr_reg <= (rd_ptr_reg + 16'h0001) & ptr_msk;
      mem_cnt_reg <= cnt_next;
      out_valid_reg <= ov_next;
      flags_reg[0] <= (cnt_next == depth);                                      // RULE_15
      flags_reg[1] <= fwft ? ~ov_next : (cnt_next == 17'h0);
      flags_reg[2] <= (total >= {1'b0, afull_lvl_reg});                         // RULE_16
      flags_reg[3] <= (total <= {1'b0, aempty_lvl_reg});
    end
  end

  assign FIFO_FULL   = flags_reg[0];
  assign FIFO_EMPTY  = flags_reg[1];
  assign FIFO_AFULL  = flags_reg[2];
  assign FIFO_AEMPTY = flags_reg[3];

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      enc_chk_reg <= 8'h00;
      dec_reg <= 66'h0;
    end else begin
      enc_chk_reg <= ecc_gen(ENC_DIN);                                          // RULE_13
      dec_reg <= ecc_fix(DEC_DIN, DEC_CHK);
    end
  end

  assign ENC_CHK  = enc_chk_reg;
  assign DEC_DOUT = dec_reg[63:0];
  assign DEC_SBE  = dec_reg[64];
  assign DEC_DBE  = dec_reg[65];

  // Zero-wait APB slave: answer is prepared in the setup cycle
  wire setup = PSEL && !PENABLE;
  wire mapped = (PADDR == `DPB_OFS_CTRL) || (PADDR == `DPB_OFS_AFULL) ||
                (PADDR == `DPB_OFS_AEMPTY) || (PADDR == `DPB_OFS_STATUS);

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= `DPB_CTRL_RST;
      afull_lvl_reg <= `DPB_AFULL_RST;
      aempty_lvl_reg <= `DPB_AEMPTY_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup && !PWRITE) begin
        case (PADDR)
          `DPB_OFS_CTRL:   prdata_reg <= ctrl_reg;
          `DPB_OFS_AFULL:  prdata_reg <= {16'h0000, afull_lvl_reg};
          `DPB_OFS_AEMPTY: prdata_reg <= {16'h0000, aempty_lvl_reg};
          `DPB_OFS_STATUS: prdata_reg <= {9'h000, out_valid_reg, flags_reg, 1'b0,
                                          mem_cnt_reg};
          default:         prdata_reg <= 32'h0000_0000;
        endcase
      end
      if (PSEL && PENABLE && PWRITE && pready_reg) begin
        case (PADDR)
          `DPB_OFS_CTRL:   ctrl_reg <= {12'h000, PWDATA[19:0]};
          `DPB_OFS_AFULL:  afull_lvl_reg <= PWDATA[15:0];
          `DPB_OFS_AEMPTY: aempty_lvl_reg <= PWDATA[15:0];
          default:         ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = pslverr_reg;

endmodule // dpb_ram36

// [dpb_ram36_asserts.sv]
// Purpose: Checker for dpb_ram36 bus timing, queue flags and codec
// Assumes: One clock; flags are registered levels
// Notes:   Sees top-level ports only; bound to every instance
`timescale 1ns/100ps
module dpb_ram36_asserts (
  input wire        CORE_CLK,   // Core clock
  input wire        RST_B,      // Reset, active low
  input wire        PSEL,       // APB select
  input wire        PENABLE,    // APB enable
  input wire        PREADY,     // APB ready
  input wire        A_EN,       // Port A enable
  input wire [63:0] A_DOUT,     // Port A read data
  input wire        FIFO_WR_EN, // Queue write
  input wire        FIFO_RD_EN, // Queue read
  input wire        FIFO_FULL,  // Queue full
  input wire        FIFO_EMPTY, // Queue empty
  input wire        FIFO_AEMPTY,// Queue almost empty
  input wire [63:0] ENC_DIN,    // Encoder data
  input wire [7:0]  ENC_CHK,    // Encoder check bits
  input wire [63:0] DEC_DIN,    // Decoder data
  input wire [7:0]  DEC_CHK,    // Decoder check bits
  input wire [63:0] DEC_DOUT,   // Decoder output
  input wire        DEC_SBE,    // Single error
  input wire        DEC_DBE     // Double error
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  chk_apb_answer: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("APB ready not a single cycle after setup");
  chk_full_holds: assert property (FIFO_FULL && !FIFO_RD_EN |=> FIFO_FULL)
    else $error("Full queue changed without a read");
  chk_empty_holds: assert property ((FIFO_EMPTY && !FIFO_WR_EN) [*3] |=> FIFO_EMPTY)
    else $error("Empty queue changed without a write");
  chk_empty_cause: assert property ($fell(FIFO_EMPTY) |->
    $past(FIFO_WR_EN) || $past(FIFO_WR_EN, 2) || $past(FIFO_WR_EN, 3))
    else $error("Empty fell with no recent write");
  chk_empty_aempty: assert property (FIFO_EMPTY |-> FIFO_AEMPTY)
    else $error("Empty without almost empty");
  chk_dout_hold: assert property (!(A_EN || FIFO_WR_EN) [*3] |=> $stable(A_DOUT))
    else $error("Port A output moved without access");
  chk_enc_stable: assert property ($stable(ENC_DIN) [*2] |=> $stable(ENC_CHK))
    else $error("Check bits moved with steady data");
  chk_dec_stable: assert property (($stable(DEC_DIN) && $stable(DEC_CHK)) [*2]
    |=> $stable(DEC_DOUT))
    else $error("Decoder output moved with steady input");
  chk_err_excl: assert property (!(DEC_SBE && DEC_DBE))
    else $error("Single and double error both set");
  cover property (FIFO_FULL);
  cover property ($fell(FIFO_EMPTY));
  cover property (DEC_SBE);
endmodule // dpb_ram36_asserts
bind dpb_ram36 dpb_ram36_asserts dpb_ram36_asserts_inst (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .A_EN(A_EN), .A_DOUT(A_DOUT),
  .FIFO_WR_EN(FIFO_WR_EN), .FIFO_RD_EN(FIFO_RD_EN), .FIFO_FULL(FIFO_FULL),
  .FIFO_EMPTY(FIFO_EMPTY), .FIFO_AEMPTY(FIFO_AEMPTY), .ENC_DIN(ENC_DIN), .ENC_CHK(ENC_CHK),
  .DEC_DIN(DEC_DIN), .DEC_CHK(DEC_CHK), .DEC_DOUT(DEC_DOUT), .DEC_SBE(DEC_SBE),
  .DEC_DBE(DEC_DBE));

// [dpb_user_model.sv]
// Purpose: User logic that drains the queue with random stalls
// Assumes: Empty flag is a registered level
// Notes:   Never asks for a read while empty is set
`timescale 1ns/100ps
module dpb_user_model (
  input  wire clk,   // Core clock
  input  wire rst_b, // Reset, active low
  input  wire go,    // Drain enable
  input  wire empty, // Queue empty
  output wire rd_en  // Queue read request
);
  reg stall_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      stall_reg <= 1'b1;
    else
      stall_reg <= ($urandom % 3) == 0;
  end
  // Gated by empty so this side never makes a refused read
  assign rd_en = go && !empty && !stall_reg;
endmodule // dpb_user_model

// [testbench.sv]
// Purpose: Self-checking bench for dpb_ram36
// Assumes: Zero-wait APB slave; one clock
// Notes:   Drivers queue notes; the negedge monitor compares them when due
`timescale 1ns/100ps
module testbench;
  typedef struct {int due; int sel; logic [71:0] exp; logic [71:0] msk;} dpb_note_t;
  reg CORE_CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0, fwft = 0;
  reg A_EN = 0, A_WE = 0, B_EN = 0, B_WE = 0, FIFO_WR_EN = 0;
  reg [7:0] PADDR = 0, A_DINP = 0, B_DINP = 0, DEC_CHK = 0;
  reg [31:0] PWDATA = 0;
  reg [15:0] A_ADDR = 0, B_ADDR = 0;
  reg [63:0] A_DIN = 0, B_DIN = 0, ENC_DIN = 0, DEC_DIN = 0;
  wire A_HALF = 1'b0, B_HALF = 1'b0, A_CASC_IN = 1'b0, B_CASC_IN = 1'b0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, A_SBE, A_DBE, B_SBE, B_DBE, FIFO_RD_EN, FIFO_FULL, FIFO_EMPTY;
  wire FIFO_AFULL, FIFO_AEMPTY, DEC_SBE, DEC_DBE;
  wire [63:0] A_DOUT, B_DOUT, DEC_DOUT;
  wire [7:0] A_DOUTP, B_DOUTP, ENC_CHK;
  int cyc = 0, to = 0, failures = 0, cmp_count = 0, cnt, i, k, r;
  logic [63:0] d, w, w0, fl;
  logic [7:0] ra [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [31:0] rv [4] = '{32'h0, 32'h7FF0, 32'h10, 32'h0};
  dpb_note_t n, n2, pq[$], aq[$];
  logic [63:0] mq[$];
  dpb_ram36 dpb_ram36_inst (.*);
  dpb_user_model dpb_user_model_inst (.clk(CORE_CLK), .rst_b(RST_B), .go(go),
    .empty(FIFO_EMPTY), .rd_en(FIFO_RD_EN));
  initial begin
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  function [71:0] obs(input int s);
    case (s)
      0: obs = {A_DOUTP, A_DOUT};
      1: obs = {B_DOUTP, B_DOUT};
      2: obs = {FIFO_FULL, FIFO_EMPTY, FIFO_AFULL, FIFO_AEMPTY};
      4: obs = {A_DBE, A_SBE, B_DBE, B_SBE};
      default: obs = {DEC_DBE, DEC_SBE, DEC_DOUT};
    endcase
  endfunction
  task chk(input [71:0] g, input [71:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task note(input int dl, input int s, input [71:0] e, input [71:0] m);
    pq.push_back('{cyc + dl, s, e, m});
  endtask
  task final_report;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Cycle count moves on the falling edge so drivers never race it
  always @(negedge CORE_CLK) begin
    cyc = cyc + 1;
    while (pq.size() > 0 && pq[0].due <= cyc) begin
      n = pq.pop_front();
      chk(obs(n.sel) & n.msk, n.exp & n.msk);
    end
  end
  always @(posedge CORE_CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      n2 = aq.pop_front();
      chk({PSLVERR, PRDATA}, n2.exp);
    end
    if (FIFO_RD_EN && !FIFO_EMPTY && mq.size() > 0) begin
      w = mq.pop_front();
      if (!fwft)
        note(1, 1, w, 32'hFFFFFFFF);
      else if (mq.size() > 0)
        note(1, 1, mq[0], 32'hFFFFFFFF);
    end
    to = to + 1;
    if (to == 20000) begin
      failures = failures + 1;
      final_report();
    end
  end
  task apb(input bit wr, input [7:0] a, input [31:0] dt, input [32:0] e);
    if (!wr)
      aq.push_back('{0, 0, e, 0});
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= dt;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task port(input bit b, input bit we, input [15:0] ad, input [63:0] dt, input int lat,
            input [63:0] e);
    if (b) begin
      B_EN <= 1'b1;
      B_WE <= we;
      B_ADDR <= ad;
      B_DIN <= dt;
      B_DINP <= dt[7:0];
    end else begin
      A_EN <= 1'b1;
      A_WE <= we;
      A_ADDR <= ad;
      A_DIN <= dt;
      A_DINP <= dt[7:0];
    end
    if (lat > 0) begin
      note(lat + 1, b, {e[7:0], e}, {8'h0F, 64'hFFFFFFFF});
      note(lat + 1, 4, 0, 4'hF);
    end
    @(posedge CORE_CLK);
    A_EN <= 1'b0;
    B_EN <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
  endtask
  task fw(input [63:0] dt, input bit fg);
    FIFO_WR_EN <= 1'b1;
    A_DIN <= dt;
    if (mq.size() < 1024)
      mq.push_back(dt);
    cnt = mq.size();
    if (fg)
      note(2, 2, {cnt == 1024, cnt == 0, cnt >= 1000, cnt <= 2}, 4'hF);
    @(posedge CORE_CLK);
  endtask
  task drain;
    go <= 1'b1;
    for (k = 0; k < 5000 && !(FIFO_EMPTY === 1'b1 && mq.size() == 0); k++)
      @(posedge CORE_CLK);
    go <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  initial begin
    void'($urandom(32'hACCE9E21));
    repeat (2) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    for (i = 0; i < 4; i++)
      apb(0, ra[i], 0, {i == 3, rv[i]});
    $display("Test registers done");
    // Both ports x36; A shows old data on write, B has the output pipe
    apb(1, 8'h00, 32'h602D, 0);
    for (i = 0; i < 4; i++) begin
      d = {$urandom, $urandom};
      port(0, 1, i, d, 0, 0);
      port(1, 0, i, 0, 2, d);
      port(0, 1, i, ~d, 1, d);
      port(0, 0, i, 0, 1, ~d);
    end
    $display("Test ports done");
    apb(1, 8'h04, 32'h3E8, 0);
    apb(1, 8'h08, 32'h2, 0);
    apb(1, 8'h00, 32'h42D, 0);
    // One write past full must be ignored
    for (i = 0; i < 1025; i++)
      fw({$urandom, $urandom}, 1);
    FIFO_WR_EN <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    apb(0, 8'h0C, 0, 33'h140400);
    drain();
    apb(0, 8'h0C, 0, 33'h280000);
    $display("Test queue done");
    apb(1, 8'h00, 32'hC2D, 0);
    fwft = 1'b1;
    w0 = {$urandom, $urandom};
    fw(w0, 0);
    fw({$urandom, $urandom}, 0);
    FIFO_WR_EN <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    note(1, 1, w0, 32'hFFFFFFFF);
    note(1, 2, 4'h1, 4'hF);
    @(posedge CORE_CLK);
    drain();
    fwft = 1'b0;
    $display("Test fall-through done");
    for (i = 0; i < 3; i++) begin
      d = {$urandom, $urandom};
      r = $urandom % 63;
      fl = (i == 0) ? 64'h0 : (i == 1) ? (64'h1 << r) : (64'h3 << r);
      ENC_DIN <= d;
      repeat (2) @(posedge CORE_CLK);
      DEC_DIN <= d ^ fl;
      DEC_CHK <= ENC_CHK;
      note(2, 3, {i == 2, i == 1, d}, {2'h3, (i == 2) ? 64'h0 : ~64'h0});
      repeat (3) @(posedge CORE_CLK);
    end
    $display("Test codec done");
    final_report();
  end
endmodule // testbench
